/* inc/tx_guard_pkg.sv */
// constants and types shared by the transmit guard and its bit buffer
package tx_guard_pkg;

  // bit-clock periods after reset release before the driver may act
  localparam logic [5:0] START_LAST = 6'h21;
  // bit times of continuous low transmit input before it is blocked
  localparam logic [5:0] STUCK_LAST = 6'h0a;
  // idle high bit times taken as inter-frame space
  localparam logic [5:0] IFS_LAST = 6'h0a;
  localparam logic [5:0] CNT_ZERO = 6'h00;

  // arbitration event word: transmitted bit above read-back bit
  localparam int unsigned WORD_W = 2;
  localparam int unsigned WORD_TX = 1;
  localparam int unsigned WORD_RX = 0;

  localparam logic [1:0] BUF_FULL = 2'h2;
  localparam logic [1:0] BUF_EMPTY = 2'h0;

  typedef enum logic [1:0] {
    GATE_WAIT = 2'b00,
    GATE_ARMED = 2'b01,
    GATE_HOT = 2'b10
  } gate_e;

  function automatic logic [5:0] sat_inc(input logic [5:0] v,
                                         input logic [5:0] lim);
    sat_inc = (v == lim) ? v : v + 6'h01;
  endfunction

endpackage

/* rtl/tx_pair_buffer.sv */
// two-entry valid/ready buffer for arbitration event words
module tx_pair_buffer
  import tx_guard_pkg::*;
#(
  parameter int unsigned WIDTH = WORD_W
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  logic [WIDTH-1:0] mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic [WIDTH-1:0] next_mem [2];
  logic next_wr_ptr;
  logic next_rd_ptr;
  logic [1:0] next_count;
  logic push;
  logic pop;

  assign in_ready = (count != BUF_FULL);
  assign out_valid = (count != BUF_EMPTY);
  assign out_data = mem[rd_ptr];

  always_comb begin
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr = ~wr_ptr;
    end
    if (pop) begin
      next_rd_ptr = ~rd_ptr;
    end
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      mem[0] <= '0;
      mem[1] <= '0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= BUF_EMPTY;
    end else begin
      mem <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

endmodule

/* rtl/bus_transceiver_tx_guard.sv */
// transmit guard of a single-wire clocked bus transceiver
// What this block does
// - in normal mode each read-back bit is compared with the sent bit
// - on mismatch flag lost arbitration, stop driving, act as receiver
// - arbitration covers every frame field after its first low bit
// - toggle is high then low; a permanently low input is never data
// - driver stays off while transmit is low and unarmed, arms on high
// - toggle needed after reset, thermal recovery, entering normal or sleep
// - in normal mode, low input beyond ten bit times stops reaching the bus
// - driver idle high for 33 bit clocks after reset release
// - clock pin is open-drain output when role select high, else input
// - after overheat, driver returns only when cool and transmit toggled
module bus_transceiver_tx_guard
  import tx_guard_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic bus_clk,
  input wire logic txd_in,
  input wire logic sleep_control_n,
  input wire logic role_select,
  input wire logic over_temp,
  input wire logic bus_in,
  output logic bus_out,
  output logic bus_oe,
  output logic rxd_out,
  output logic clk_pin_out,
  output logic clk_pin_oe,
  output logic link_ready,
  output logic arb_lost,
  output logic stuck_low,
  output logic event_overrun,
  output logic [WORD_W-1:0] event_data,
  output logic event_valid,
  input wire logic event_ready
);

  // ---------------- core domain: pin synchronisers ----------------
  logic txd_c1, txd_c2, slp_c1, slp_c2, role_c1, role_c2;
  logic hot_c1, hot_c2, bus_c1, bus_c2;
  logic started_c1, started_c2, lost_c1, lost_c2;
  logic stuck_c1, stuck_c2, ovr_c1, ovr_c2, req_c1, req_c2;

  // ---------------- link domain signals ----------------
  logic rst_l1, rst_l2;
  logic txd_l1, txd_l2, txd_l3, bus_l1, bus_l2, norm_l1, norm_l2;
  logic ack_l1, ack_l2;
  logic [5:0] start_cnt, low_cnt, ifs_cnt;
  logic [5:0] next_start_cnt, next_low_cnt, next_ifs_cnt;
  logic started_l, stuck_l, lost_l, in_frame, req_l, overrun_l;
  logic next_started_l, next_stuck_l, next_lost_l, next_in_frame;
  logic next_req_l, next_overrun_l;
  logic [WORD_W-1:0] word_l, next_word_l;
  logic ifs_seen, mismatch;

  // ---------------- core domain state ----------------
  gate_e gate, next_gate;
  logic prev_norm, next_prev_norm;
  logic next_bus_oe, next_rxd_out, next_clk_pin_oe;
  logic ack_c, next_ack_c;
  logic tx_enable, pend, push, buf_ready;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      txd_c1 <= 1'b1;
      txd_c2 <= 1'b1;
      slp_c1 <= 1'b0;
      slp_c2 <= 1'b0;
      role_c1 <= 1'b0;
      role_c2 <= 1'b0;
      hot_c1 <= 1'b0;
      hot_c2 <= 1'b0;
      bus_c1 <= 1'b1;
      bus_c2 <= 1'b1;
      started_c1 <= 1'b0;
      started_c2 <= 1'b0;
      lost_c1 <= 1'b0;
      lost_c2 <= 1'b0;
      stuck_c1 <= 1'b0;
      stuck_c2 <= 1'b0;
      ovr_c1 <= 1'b0;
      ovr_c2 <= 1'b0;
      req_c1 <= 1'b0;
      req_c2 <= 1'b0;
    end else begin
      txd_c1 <= txd_in;
      txd_c2 <= txd_c1;
      slp_c1 <= sleep_control_n;
      slp_c2 <= slp_c1;
      role_c1 <= role_select;
      role_c2 <= role_c1;
      hot_c1 <= over_temp;
      hot_c2 <= hot_c1;
      bus_c1 <= bus_in;
      bus_c2 <= bus_c1;
      started_c1 <= started_l;
      started_c2 <= started_c1;
      lost_c1 <= lost_l;
      lost_c2 <= lost_c1;
      stuck_c1 <= stuck_l;
      stuck_c2 <= stuck_c1;
      ovr_c1 <= overrun_l;
      ovr_c2 <= ovr_c1;
      req_c1 <= req_l;
      req_c2 <= req_c1;
    end
  end

  // ---------------- core domain: toggle gate ----------------
  always_comb begin
    next_gate = gate;
    next_prev_norm = slp_c2;
    if (hot_c2) begin
      next_gate = GATE_HOT;
    end else if (!started_c2 || (slp_c2 != prev_norm)) begin
      // any mode change or pending startup demands a fresh toggle
      next_gate = GATE_WAIT;
    end else begin
      case (gate)
        GATE_HOT: next_gate = GATE_WAIT;
        GATE_WAIT: begin
          // a low level never arms; only a high seen first does
          if (txd_c2) begin
            next_gate = GATE_ARMED;
          end
        end
        GATE_ARMED: next_gate = GATE_ARMED;
        default: next_gate = GATE_WAIT;
      endcase
    end
  end

  always_comb begin
    // lost arbitration and stuck-low only bind in normal mode
    tx_enable = (gate == GATE_ARMED) &&
                !(slp_c2 && (lost_c2 || stuck_c2));
    next_bus_oe = tx_enable && !txd_c2;
    next_rxd_out = bus_c2;
    next_clk_pin_oe = role_c2 && !bus_c2;
    pend = (req_c2 != ack_c);
    push = pend && buf_ready;
    next_ack_c = push ? req_c2 : ack_c;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      gate <= GATE_WAIT;
      prev_norm <= 1'b0;
      bus_oe <= 1'b0;
      rxd_out <= 1'b1;
      clk_pin_oe <= 1'b0;
      ack_c <= 1'b0;
    end else begin
      gate <= next_gate;
      prev_norm <= next_prev_norm;
      bus_oe <= next_bus_oe;
      rxd_out <= next_rxd_out;
      clk_pin_oe <= next_clk_pin_oe;
      ack_c <= next_ack_c;
    end
  end

  assign bus_out = 1'b0;
  assign clk_pin_out = 1'b0;
  assign link_ready = started_c2;
  assign arb_lost = lost_c2;
  assign stuck_low = stuck_c2;
  assign event_overrun = ovr_c2;

  // word_l is held stable by the link until ack returns
  tx_pair_buffer #(
    .WIDTH(WORD_W)
  ) u_events (
    .core_clk(core_clk),
    .reset(reset),
    .in_data(word_l),
    .in_valid(pend),
    .in_ready(buf_ready),
    .out_data(event_data),
    .out_valid(event_valid),
    .out_ready(event_ready)
  );

  // ---------------- link domain: synchronisers ----------------
  // bus_clk must run during reset so the link reset can propagate
  always_ff @(posedge bus_clk) begin
    rst_l1 <= reset;
    rst_l2 <= rst_l1;
    txd_l1 <= txd_in;
    txd_l2 <= txd_l1;
    txd_l3 <= txd_l2;
    bus_l1 <= bus_in;
    bus_l2 <= bus_l1;
    norm_l1 <= slp_c2;
    norm_l2 <= norm_l1;
    ack_l1 <= ack_c;
    ack_l2 <= ack_l1;
  end

  // ---------------- link domain: bit-time logic ----------------
  always_comb begin
    next_start_cnt = sat_inc(start_cnt, START_LAST);
    next_started_l = (next_start_cnt == START_LAST);
    if (txd_l2 || !norm_l2) begin
      next_low_cnt = CNT_ZERO;
    end else begin
      next_low_cnt = sat_inc(low_cnt, STUCK_LAST);
    end
    next_stuck_l = (next_low_cnt == STUCK_LAST);
    if (txd_l2 && bus_l2) begin
      next_ifs_cnt = sat_inc(ifs_cnt, IFS_LAST);
    end else begin
      next_ifs_cnt = CNT_ZERO;
    end
    ifs_seen = (ifs_cnt == IFS_LAST);
    // a low bit of ours reads back low or was never driven, so only a
    // high bit can be overridden; judging it after two equal samples
    // keeps the driver's release delay from passing for a loss
    mismatch = in_frame && norm_l2 && txd_l2 && txd_l3 &&
               !bus_l2;
    next_in_frame = in_frame;
    next_lost_l = lost_l;
    next_req_l = req_l;
    next_word_l = word_l;
    next_overrun_l = overrun_l;
    if (ifs_seen || !norm_l2) begin
      next_in_frame = 1'b0;
      next_lost_l = 1'b0;
      next_overrun_l = 1'b0;
    end else begin
      if (started_l && !txd_l2) begin
        next_in_frame = 1'b1;
      end
      if (mismatch) begin
        next_lost_l = 1'b1;
      end
      if (mismatch && !lost_l) begin
        if (req_l != ack_l2) begin
          next_overrun_l = 1'b1;
        end else begin
          next_req_l = ~req_l;
          next_word_l[WORD_TX] = txd_l2;
          next_word_l[WORD_RX] = bus_l2;
        end
      end
    end
  end

  always_ff @(posedge bus_clk) begin
    if (rst_l2) begin
      start_cnt <= CNT_ZERO;
      low_cnt <= CNT_ZERO;
      ifs_cnt <= CNT_ZERO;
      started_l <= 1'b0;
      stuck_l <= 1'b0;
      lost_l <= 1'b0;
      in_frame <= 1'b0;
      req_l <= 1'b0;
      overrun_l <= 1'b0;
      word_l <= '0;
    end else begin
      start_cnt <= next_start_cnt;
      low_cnt <= next_low_cnt;
      ifs_cnt <= next_ifs_cnt;
      started_l <= next_started_l;
      stuck_l <= next_stuck_l;
      lost_l <= next_lost_l;
      in_frame <= next_in_frame;
      req_l <= next_req_l;
      overrun_l <= next_overrun_l;
      word_l <= next_word_l;
    end
  end

  // ---------------- checks ----------------
  a_drive_needs_arm: assert property (@(posedge core_clk) disable iff (reset)
    bus_oe |-> $past(gate) == GATE_ARMED)
    else $error("bus driven without armed gate");

  a_low_never_arms: assert property (@(posedge core_clk) disable iff (reset)
    (gate == GATE_WAIT && !txd_c2) |=> gate != GATE_ARMED)
    else $error("gate armed by low transmit input");

  a_hot_blocks_drive: assert property (@(posedge core_clk)
    disable iff (reset)
    hot_c2 |-> ##2 !bus_oe)
    else $error("bus driven during overtemperature");

  a_lost_stops_drive: assert property (@(posedge core_clk)
    disable iff (reset)
    (lost_c2 && slp_c2) |=> !bus_oe)
    else $error("bus driven after lost arbitration");

  a_stuck_stops_drive: assert property (@(posedge core_clk)
    disable iff (reset)
    (stuck_c2 && slp_c2) |=> !bus_oe)
    else $error("stuck low input reached the bus");

  a_mode_change_disarm: assert property (@(posedge core_clk)
    disable iff (reset)
    (slp_c2 != prev_norm && !hot_c2) |=> gate == GATE_WAIT)
    else $error("mode change kept the gate armed");

  a_startup_quiet: assert property (@(posedge core_clk) disable iff (reset)
    !started_c2 |=> !bus_oe)
    else $error("bus driven before startup count");

  a_clk_pin_input: assert property (@(posedge core_clk) disable iff (reset)
    !role_c2 |=> !clk_pin_oe)
    else $error("clock pin driven while an input");

  a_mismatch_loses: assert property (@(posedge bus_clk) disable iff (rst_l2)
    (mismatch && !ifs_seen) |=> lost_l)
    else $error("bit mismatch did not flag loss");

  a_low_count_restart: assert property (@(posedge bus_clk)
    disable iff (rst_l2)
    txd_l2 |=> low_cnt == CNT_ZERO)
    else $error("stuck count not restarted by high");

  a_startup_count: assert property (@(posedge bus_clk) disable iff (rst_l2)
    $rose(started_l) |-> start_cnt == START_LAST &&
      $past(start_cnt) == START_LAST - 6'h01)
    else $error("startup ended at wrong count");

endmodule

/* tb/bus_node_model.sv */
// wired bus and clock pin at the far side, with one contending node
module bus_node_model (
  input wire logic bus_out,
  input wire logic bus_oe,
  input wire logic other_pull,
  input wire logic clk_pin_out,
  input wire logic clk_pin_oe,
  output logic bus_in,
  output logic clk_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  // pull-up: a released wire reads high, any pull wins
  assign bus_in = !((bus_oe && !bus_out) || other_pull);
  // clock pin pull-up when nobody sinks it
  assign clk_wire = clk_pin_oe ? clk_pin_out : 1'b1;
endmodule

/* tb/tb_top.sv */
// self-checking bench for the transmit guard
module tb_top
  import tx_guard_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, bus_clk, reset, txd_in, sleep_control_n, role_select;
  logic over_temp, other_pull, event_ready, bus_in, bus_out, bus_oe;
  logic rxd_out, clk_pin_out, clk_pin_oe, link_ready, arb_lost, stuck_low;
  logic event_overrun, event_valid, clk_wire;
  logic [WORD_W-1:0] event_data;
  logic [WORD_W-1:0] exp_q[$];
  logic [31:0] rnd;
  int mismatches, cmp_count, cycles, n;

  bus_transceiver_tx_guard dut (.core_clk, .reset, .bus_clk, .txd_in,
    .sleep_control_n, .role_select, .over_temp, .bus_in, .bus_out, .bus_oe,
    .rxd_out, .clk_pin_out, .clk_pin_oe, .link_ready, .arb_lost, .stuck_low,
    .event_overrun, .event_data, .event_valid, .event_ready);
  bus_node_model far_side (.bus_out, .bus_oe, .other_pull, .clk_pin_out,
    .clk_pin_oe, .bus_in, .clk_wire);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // link clock offset so its edges never line up with the core clock
  initial begin
    bus_clk = 1'b0;
    #7;
    forever #15 bus_clk = ~bus_clk;
  end

  task automatic give_verdict;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string what);
    cmp_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic bits(input int k);
    repeat (k) @(posedge bus_clk);
    cyc(1);
  endtask
  // contender moves together with us so both start a frame at once
  task automatic drive(input logic t, input logic p);
    txd_in = t;
    other_pull = p;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic arb_round;
    drive(1'b0, 1'b1);
    bits(2);
    chk(arb_lost === 1'b0, "loss while bits match");
    exp_q.push_back(2'h2);
    drive(1'b1, 1'b1);
    bits(5);
    cyc(3);
    chk(arb_lost === 1'b1, "loss not flagged");
    drive(1'b0, 1'b1);
    cyc(6);
    chk(bus_oe === 1'b0, "drives after loss");
    drive(1'b1, 1'b0);
    bits(14);
    chk(arb_lost === 1'b0, "loss not cleared at idle");
  endtask

  always @(posedge core_clk) begin
    if (!reset && event_valid === 1'b1 && event_ready === 1'b1) begin
      cmp_count++;
      if (exp_q.size() == 0 || exp_q.pop_front() !== event_data) begin
        mismatches++;
        $display("MISMATCH %0t unexpected event word", $time);
      end
    end
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    reset = 1'b1;
    txd_in = 1'b0;
    sleep_control_n = 1'b1;
    role_select = 1'b1;
    over_temp = 1'b0;
    other_pull = 1'b0;
    event_ready = 1'b0;
    rnd = 32'h0000_4280;
    cyc(16);
    reset = 1'b0;
    cyc(1);
    chk(bus_oe === 1'b0 && rxd_out === 1'b1, "reset outputs");
    chk(link_ready === 1'b0, "ready too soon");
    n = 0;
    while (link_ready !== 1'b1 && n < 60) begin
      @(posedge bus_clk);
      n++;
      cyc(1);
    end
    chk(n >= 33 && n <= 40, "start-up bit count");
    bits(3);
    chk(bus_oe === 1'b0, "low input drove without toggle");
    other_pull = 1'b1;
    cyc(6);
    chk(clk_pin_oe === 1'b1, "clock pin not driven");
    chk(rxd_out === 1'b0, "receive not low");
    other_pull = 1'b0;
    cyc(6);
    chk(clk_pin_oe === 1'b0 && clk_wire === 1'b1, "clock pin held");
    txd_in = 1'b1;
    cyc(5);
    sleep_control_n = 1'b0;
    cyc(6);
    chk(rxd_out === 1'b1 && clk_pin_oe === 1'b0, "pins before switch");
    role_select = 1'b0;
    other_pull = 1'b1;
    cyc(6);
    chk(clk_pin_oe === 1'b0, "input role drove clock pin");
    drive(1'b0, 1'b0);
    sleep_control_n = 1'b1;
    cyc(10);
    chk(bus_oe === 1'b0, "first normal frame without toggle");
    txd_in = 1'b1;
    cyc(5);
    drive(1'b0, 1'b1);
    cyc(5);
    chk(bus_oe === 1'b1, "toggle did not arm");
    bits(7);
    chk(bus_oe === 1'b1 && stuck_low === 1'b0, "blocked early");
    bits(5);
    chk(stuck_low === 1'b1 && bus_oe === 1'b0, "stuck low passed");
    drive(1'b1, 1'b0);
    bits(2);
    drive(1'b0, 1'b1);
    cyc(5);
    chk(bus_oe === 1'b1 && stuck_low === 1'b0, "count not restarted");
    drive(1'b1, 1'b0);
    cyc(6);
    chk(bus_oe === 1'b0, "drives with input high");
    bits(12);
    arb_round();
    arb_round();
    chk(event_valid === 1'b1 && event_overrun === 1'b0, "events held");
    repeat (40) begin
      rnd = lfsr(rnd);
      event_ready = rnd[0];
      cyc(1);
    end
    event_ready = 1'b1;
    cyc(4);
    chk(exp_q.size() == 0 && event_valid === 1'b0, "events lost");
    drive(1'b0, 1'b1);
    cyc(5);
    chk(bus_oe === 1'b1, "frame not driven");
    over_temp = 1'b1;
    cyc(6);
    chk(bus_oe === 1'b0, "drives while hot");
    over_temp = 1'b0;
    cyc(6);
    chk(bus_oe === 1'b0, "rearmed without toggle");
    drive(1'b1, 1'b0);
    bits(12);
    txd_in = 1'b0;
    cyc(5);
    chk(bus_oe === 1'b1, "no drive after cool toggle");
    txd_in = 1'b1;
    bits(12);
    give_verdict();
  end
endmodule
